/* rtl/eapr_regs.sv */
`timescale 1ns/1ps
module eapr_regs #(
  parameter logic [7:0] FACTORY_CDA = eapr_pkg::CDA_RESET,
  parameter logic [7:0] FACTORY_SWP = eapr_pkg::SWP_RESET,
  parameter int         WCYC_CYCLES = eapr_pkg::WCYC_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  input  wire logic                  write_control_n_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  output logic                       busy_o,
  output logic [1:0]                 chip_enable_o,
  output eapr_pkg::eapr_protect_s    protect_o
);
  import eapr_pkg::*;

  localparam int CW = $clog2(WCYC_CYCLES + 1);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (WCYC_CYCLES < 1 || (FACTORY_CDA & ~CDA_MASK) != 8'h00 || (FACTORY_SWP & ~SWP_MASK) != 8'h00) begin : g_bad
    $error("eapr_regs: bad write cycle length or reserved bits set in factory values");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  eapr_bus_ev_s  ev;
  eapr_state_e   state_r;
  eapr_kind_e    kind_r;
  eapr_tgt_e     tgt_r;
  eapr_tgt_e     wtgt_r;
  logic [2:0]    cnt_r;
  logic          rx_full_r;
  logic [7:0]    sh_r;
  logic          rd_r;
  logic          mack_r;
  logic          seen_data_r;
  logic          wr_arm_r;
  logic [7:0]    pend_r;
  logic          oe_r;
  logic          busy_r;
  logic [CW-1:0] wcnt_r;
  logic          apply_r;
  logic          reload_r;
  logic [7:0]    nv_cda_r;
  logic [7:0]    nv_swp_r;
  logic [7:0]    cda_r;
  logic [7:0]    swp_r;
  logic          wc_meta_r;
  logic          wc_sync_r;
  logic          dev_hit;
  logic          data_ok;
  logic          ack_now;
  logic          commit;
  logic [7:0]    rdata;
  logic [7:0]    wmask;

  // ****************************************************************
  // Pin conditioning
  // ****************************************************************
  eapr_i2c_bit u_bit (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .ev_o   (ev)
  );

  // Write control is asynchronous to clk_i; reset low so writes are enabled.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wc_meta_r <= 1'b0;
      wc_sync_r <= 1'b0;
    end else begin
      wc_meta_r <= write_control_n_i;
      wc_sync_r <= wc_meta_r;
    end
  end

  // ****************************************************************
  // Byte decisions
  // ****************************************************************
  // Select match uses the live chip enables; a running write cycle hides the device.
  always_comb begin
    dev_hit = (sh_r[7:4] == TYPE_ID) && !busy_r &&
              (sh_r[3:2] == {cda_r[CDA_CEH_BIT], cda_r[CDA_CEL_BIT]});
    data_ok = !seen_data_r && !wc_sync_r &&
              ((tgt_r == T_CDA && !cda_r[CDA_LOCK_BIT]) ||
               (tgt_r == T_SWP && !swp_r[SWP_LOCK_BIT]));
    unique case (kind_r)
      K_DEV:   ack_now = dev_hit;
      K_AHI:   ack_now = 1'b1;
      K_ALO:   ack_now = 1'b1;
      K_DATA:  ack_now = data_ok;
    endcase
  end

  // Read data and the write mask; reserved positions are forced to zero.
  always_comb begin
    unique case (tgt_r)
      T_CDA:   rdata = cda_r & CDA_MASK;
      T_SWP:   rdata = swp_r & SWP_MASK;
      default: rdata = 8'h00;
    endcase
    wmask = (tgt_r == T_CDA) ? CDA_MASK : SWP_MASK;
  end

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  // Bits are taken on SCL rise and SDA changes on SCL fall. A start from any
  // state restarts the select byte, so a repeated start gives a random read.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r     <= ST_IDLE;
      kind_r      <= K_DEV;
      tgt_r       <= T_NONE;
      cnt_r       <= 3'h0;
      rx_full_r   <= 1'b0;
      sh_r        <= 8'h00;
      rd_r        <= 1'b0;
      mack_r      <= 1'b0;
      seen_data_r <= 1'b0;
      wr_arm_r    <= 1'b0;
      pend_r      <= 8'h00;
      oe_r        <= 1'b0;
    end else if (ev.start) begin
      state_r     <= ST_RX;
      kind_r      <= K_DEV;
      cnt_r       <= 3'h0;
      rx_full_r   <= 1'b0;
      seen_data_r <= 1'b0;
      wr_arm_r    <= 1'b0;
      oe_r        <= 1'b0;
    end else if (ev.stop) begin
      state_r   <= ST_IDLE;
      rx_full_r <= 1'b0;
      wr_arm_r  <= 1'b0;
      oe_r      <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          oe_r <= 1'b0;
        end
        ST_RX: begin
          if (ev.scl_rise && !rx_full_r) begin
            sh_r  <= {sh_r[6:0], ev.sda};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              rx_full_r <= 1'b1;
            end
          end else if (ev.scl_fall && rx_full_r) begin
            rx_full_r <= 1'b0;
            if (kind_r == K_DATA) begin
              seen_data_r <= 1'b1;
              wr_arm_r    <= data_ok;
              pend_r      <= sh_r & wmask;
            end
            if (ack_now) begin
              state_r <= ST_ACK;
              oe_r    <= 1'b1;
              unique case (kind_r)
                K_DEV: begin
                  rd_r   <= sh_r[0];
                  kind_r <= K_AHI;
                end
                K_AHI: begin
                  if (sh_r[7:5] == SEL_CDA) begin
                    tgt_r <= T_CDA;
                  end else if (sh_r[7:5] == SEL_SWP) begin
                    tgt_r <= T_SWP;
                  end else begin
                    tgt_r <= T_NONE;
                  end
                  kind_r <= K_ALO;
                end
                K_ALO:  kind_r <= K_DATA;
                K_DATA: kind_r <= K_DATA;
              endcase
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (ev.scl_fall) begin
            cnt_r <= 3'h0;
            if (rd_r) begin
              state_r <= ST_TX;
              sh_r    <= rdata;
              oe_r    <= ~rdata[7];
            end else begin
              state_r <= ST_RX;
              oe_r    <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (ev.scl_fall) begin
            if (cnt_r == 3'h7) begin
              state_r <= ST_RACK;
              oe_r    <= 1'b0;
            end else begin
              cnt_r <= cnt_r + 3'h1;
              sh_r  <= {sh_r[6:0], 1'b0};
              oe_r  <= ~sh_r[6];
            end
          end
        end
        ST_RACK: begin
          if (ev.scl_rise) begin
            mack_r <= ~ev.sda;
          end else if (ev.scl_fall) begin
            cnt_r <= 3'h0;
            if (mack_r) begin
              state_r <= ST_TX;
              sh_r    <= rdata;
              oe_r    <= ~rdata[7];
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          oe_r    <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Write cycle
  // ****************************************************************
  // Only a stop after exactly one accepted data byte launches the cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_r <= 1'b0;
      wcnt_r <= '0;
      wtgt_r <= T_NONE;
    end else if (!busy_r && ev.stop && wr_arm_r) begin
      busy_r <= 1'b1;
      wcnt_r <= CW'(WCYC_CYCLES - 1);
      wtgt_r <= tgt_r;
    end else if (busy_r) begin
      if (wcnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        wcnt_r <= wcnt_r - CW'(1);
      end
    end
  end

  assign commit = busy_r && (wcnt_r == '0);

  // Nonvolatile images; reset stands for a fresh part with its factory contents.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nv_cda_r <= FACTORY_CDA;
      nv_swp_r <= FACTORY_SWP;
    end else if (commit && wtgt_r == T_CDA) begin
      nv_cda_r <= pend_r;
    end else if (commit && wtgt_r == T_SWP) begin
      nv_swp_r <= pend_r;
    end
  end

  // Working copies reload from the images after reset and after each cycle,
  // so a half-written value never steers address match or protection.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reload_r <= 1'b1;
      apply_r  <= 1'b0;
      cda_r    <= CDA_RESET;
      swp_r    <= SWP_RESET;
    end else begin
      reload_r <= 1'b0;
      apply_r  <= commit;
      if (reload_r || apply_r) begin
        cda_r <= nv_cda_r;
        swp_r <= nv_swp_r;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_o         = 1'b0;
  assign sda_oe_o      = oe_r;
  assign busy_o        = busy_r;
  assign chip_enable_o = {cda_r[CDA_CEH_BIT], cda_r[CDA_CEL_BIT]};

  // Quarter 3 is the top of the array; the mask grows downward with the size.
  always_comb begin
    protect_o.enable     = swp_r[SWP_EN_BIT];
    protect_o.block_size = {swp_r[SWP_BSH_BIT], swp_r[SWP_BSL_BIT]};
    unique case ({swp_r[SWP_BSH_BIT], swp_r[SWP_BSL_BIT]})
      2'h0: protect_o.quarter_mask = 4'h8;
      2'h1: protect_o.quarter_mask = 4'hC;
      2'h2: protect_o.quarter_mask = 4'hE;
      2'h3: protect_o.quarter_mask = 4'hF;
    endcase
    if (!swp_r[SWP_EN_BIT]) begin
      protect_o.quarter_mask = 4'h0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [CW-1:0] busy_len_r;

  always_ff @(posedge clk_i) begin
    if (srst_i || !busy_r) begin
      busy_len_r <= '0;
    end else begin
      busy_len_r <= busy_len_r + CW'(1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_byte_done;
    state_r == ST_RX && rx_full_r && ev.scl_fall && !ev.start && !ev.stop;
  endsequence

  sequence s_data_done;
    s_byte_done ##0 kind_r == K_DATA;
  endsequence

  sequence s_armed_stop;
    ev.stop && wr_arm_r && !busy_r;
  endsequence

  AST_RSVD_ZERO: assert property ((rdata & ~wmask) == 8'h00 && (cda_r & ~CDA_MASK) == 8'h00)
    else $error("reserved register bits not zero");
  AST_CDA_LOCK: assert property (!reload_r && cda_r[CDA_LOCK_BIT] |=> cda_r == $past(cda_r))
    else $error("locked address register changed");
  AST_SWP_LOCK: assert property (!reload_r && swp_r[SWP_LOCK_BIT] |=> swp_r == $past(swp_r))
    else $error("locked protection register changed");
  AST_WC_NACK: assert property (s_data_done ##0 wc_sync_r |=> !oe_r && !wr_arm_r)
    else $error("data byte acked while write control high");
  AST_SEL_MISS: assert property (s_byte_done ##0 kind_r == K_DEV ##0 sh_r[3:2] != chip_enable_o
                                 |=> state_r == ST_IDLE && !oe_r)
    else $error("select byte with wrong chip enable answered");
  AST_SECOND_BYTE: assert property (s_data_done ##0 seen_data_r |=> !wr_arm_r ##1 !busy_r)
    else $error("second data byte did not abort the write");
  AST_STOP_CYCLE: assert property (s_armed_stop |=> busy_r [*2])
    else $error("stop after accepted write did not start cycle");
  AST_WCYC_LEN: assert property ($fell(busy_r) |-> busy_len_r == CW'(WCYC_CYCLES))
    else $error("write cycle length wrong");
  AST_APPLY_LATE: assert property (!$stable(cda_r) || !$stable(swp_r) |-> $past(apply_r) || $past(reload_r))
    else $error("register changed outside write cycle completion");
  AST_TGT_DECODE: assert property (s_byte_done ##0 kind_r == K_AHI ##0 sh_r[7:5] == SEL_CDA
                                   |=> tgt_r == T_CDA && state_r == ST_ACK)
    else $error("address register not selected by 110");
  AST_PROT_MASK: assert property (!swp_r[SWP_EN_BIT] |-> protect_o.quarter_mask == 4'h0)
    else $error("protection active while disabled");

endmodule : eapr_regs

/* rtl/eapr_pkg.sv */
package eapr_pkg;

  // ****************************************************************
  // Selection codes
  // ****************************************************************
  localparam logic [3:0] TYPE_ID  = 4'hB;
  localparam logic [2:0] SEL_CDA  = 3'h6;
  localparam logic [2:0] SEL_SWP  = 3'h5;

  // ****************************************************************
  // Register layouts and reset values
  // ****************************************************************
  localparam int         CDA_CEH_BIT  = 3;
  localparam int         CDA_CEL_BIT  = 2;
  localparam int         CDA_LOCK_BIT = 0;
  localparam logic [7:0] CDA_MASK     = 8'h0D;
  localparam logic [7:0] CDA_RESET    = 8'h00;
  localparam int         SWP_EN_BIT   = 3;
  localparam int         SWP_BSH_BIT  = 2;
  localparam int         SWP_BSL_BIT  = 1;
  localparam int         SWP_LOCK_BIT = 0;
  localparam logic [7:0] SWP_MASK     = 8'h0F;
  localparam logic [7:0] SWP_RESET    = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int WCYC_TIME_NS  = 8000;
  localparam int WCYC_CYCLES   = (WCYC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_RACK = 3'h6
  } eapr_state_e;

  typedef enum logic [1:0] {
    K_DEV  = 2'h0,
    K_AHI  = 2'h1,
    K_ALO  = 2'h3,
    K_DATA = 2'h2
  } eapr_kind_e;

  typedef enum logic [1:0] {
    T_NONE = 2'h0,
    T_CDA  = 2'h1,
    T_SWP  = 2'h2
  } eapr_tgt_e;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } eapr_bus_ev_s;

  typedef struct packed {
    logic       enable;
    logic [1:0] block_size;
    logic [3:0] quarter_mask;
  } eapr_protect_s;

endpackage : eapr_pkg

/* rtl/eapr_i2c_bit.sv */
`timescale 1ns/1ps
module eapr_i2c_bit (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output eapr_pkg::eapr_bus_ev_s     ev_o
);
  import eapr_pkg::*;

  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;

  // Two-stage synchronisers plus one delay stage for edge detection.
  // The bus idles high, so the stages reset high to avoid a false start.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Start and stop are SDA edges while SCL stays high on both samples.
  assign ev_o.scl_rise = scl_s_r & ~scl_d_r;
  assign ev_o.scl_fall = ~scl_s_r & scl_d_r;
  assign ev_o.start    = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign ev_o.stop     = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign ev_o.sda      = sda_s_r;

endmodule : eapr_i2c_bit

/* dv/eapr_i2c_ctrl.sv */
`timescale 1ns/1ps
module eapr_i2c_ctrl (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Both lines start released; the pull-up holds SDA high.
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // ****************************************************************
  // Bus conditions
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Serves as start and as repeated start, from SCL low or from idle.
  task automatic bus_start();
    sda_low_o <= 1'b0;
    tick(5);
    scl_o <= 1'b1;
    tick(10);
    sda_low_o <= 1'b1;
    tick(10);
    scl_o <= 1'b0;
    tick(5);
  endtask : bus_start

  // A stop closes every transfer; a register write is only committed here.
  task automatic bus_stop();
    sda_low_o <= 1'b1;
    tick(5);
    scl_o <= 1'b1;
    tick(10);
    sda_low_o <= 1'b0;
    tick(10);
  endtask : bus_stop

  // ****************************************************************
  // Bits and bytes
  // ****************************************************************
  // SDA moves only while SCL is low, so no bit can be mistaken for a start or stop.
  task automatic put_bit(input logic b, output logic seen);
    sda_low_o <= ~b;
    tick(5);
    scl_o <= 1'b1;
    tick(5);
    seen = sda_i;
    tick(5);
    scl_o <= 1'b0;
    tick(5);
  endtask : put_bit

  // Sends a byte MSB first, then releases SDA for the answer bit.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // Reads one byte and refuses any further one by leaving SDA released.
  task automatic recv_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
    put_bit(1'b1, s);
  endtask : recv_byte
endmodule : eapr_i2c_ctrl

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import eapr_pkg::*;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int WCYC    = 20;
  localparam int TIMEOUT = 60000;
  logic          clk_i   = 1'b0;
  logic          srst_i;
  logic          write_control_n;
  logic          scl, sda_low, sda, oe_a, oe_b, busy_a, busy_b;
  logic [1:0]    ce_a, ce_b;
  eapr_protect_s prot_a, prot_b;
  int            n_fail  = 0;
  int            tests_run = 0;
  int            cycles  = 0;
  logic          k, b;
  logic [7:0]    d;

  // Open-drain wire: any party pulling low wins, otherwise the pull-up.
  assign sda = ~(sda_low | oe_a | oe_b);

  eapr_i2c_ctrl i_eapr_i2c_ctrl (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  eapr_regs #(.WCYC_CYCLES(WCYC)) i_eapr_regs (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .write_control_n_i(write_control_n),
    .sda_o(), .sda_oe_o(oe_a), .busy_o(busy_a), .chip_enable_o(ce_a), .protect_o(prot_a));

  // Second device on the same bus, shipped with a locked preset address of 11.
  eapr_regs #(.FACTORY_CDA(8'h0D), .WCYC_CYCLES(WCYC)) i_eapr_regs_preset (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .write_control_n_i(write_control_n),
    .sda_o(), .sda_oe_o(oe_b), .busy_o(busy_b), .chip_enable_o(ce_b), .protect_o(prot_b));

  // Free-running clock.
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  // A hung bus ends the run as a failure.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Write with n data bytes; returns the first data answer and busy after the stop.
  task automatic reg_write(input logic [1:0] ce, input logic [2:0] tgt, input logic [7:0] v,
                           input int n, output logic dack, output logic bsy);
    logic a;
    i_eapr_i2c_ctrl.bus_start();
    i_eapr_i2c_ctrl.send_byte({TYPE_ID, ce, 2'b00}, a);
    check({7'h0, a}, 8'h01);
    i_eapr_i2c_ctrl.send_byte({tgt, 5'h15}, a);
    check({7'h0, a}, 8'h01);
    i_eapr_i2c_ctrl.send_byte(8'hA5, a);
    check({7'h0, a}, 8'h01);
    i_eapr_i2c_ctrl.send_byte(v, dack);
    for (int i = 1; i < n; i++) i_eapr_i2c_ctrl.send_byte(v, a);
    i_eapr_i2c_ctrl.bus_stop();
    #1;
    bsy = busy_a | busy_b;
    @(posedge clk_i);
  endtask : reg_write

  // Random-address style read of one register byte.
  task automatic reg_read(input logic [1:0] ce, input logic [2:0] tgt, output logic [7:0] v);
    logic a;
    i_eapr_i2c_ctrl.bus_start();
    i_eapr_i2c_ctrl.send_byte({TYPE_ID, ce, 2'b00}, a);
    i_eapr_i2c_ctrl.send_byte({tgt, 5'h0A}, a);
    i_eapr_i2c_ctrl.send_byte(8'h3C, a);
    i_eapr_i2c_ctrl.bus_start();
    i_eapr_i2c_ctrl.send_byte({TYPE_ID, ce, 2'b01}, a);
    i_eapr_i2c_ctrl.recv_byte(v);
    i_eapr_i2c_ctrl.bus_stop();
  endtask : reg_read

  // Select probe with no further bytes, to see whether a device answers.
  task automatic probe(input logic [1:0] ce, output logic a);
    i_eapr_i2c_ctrl.bus_start();
    i_eapr_i2c_ctrl.send_byte({TYPE_ID, ce, 2'b00}, a);
    i_eapr_i2c_ctrl.bus_stop();
  endtask : probe

  // Waits out the internal write cycle, bounded, plus settling of the working copy.
  task automatic wait_idle();
    for (int i = 0; i < 200 && (busy_a | busy_b) !== 1'b0; i++) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
  endtask : wait_idle

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : do_reset

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    srst_i          = 1'b1;
    write_control_n = 1'b0;
    do_reset();
    check({6'h0, ce_a}, 8'h00);
    check({6'h0, ce_b}, 8'h03);
    reg_read(2'd0, SEL_CDA, d);
    check(d, CDA_RESET);
    reg_read(2'd0, SEL_SWP, d);
    check(d, SWP_RESET);
    reg_read(2'd3, SEL_CDA, d);
    check(d, 8'h0D);
    reg_write(2'd0, SEL_SWP, 8'hF6, 1, k, b);
    check({7'h0, b}, 8'h01);
    wait_idle();
    reg_read(2'd0, SEL_SWP, d);
    check(d, 8'h06);
    check({6'h0, prot_a.block_size}, 8'h03);
    check({7'h0, prot_a.enable}, 8'h00);
    check({4'h0, prot_a.quarter_mask}, 8'h00);
    // The protection write must not have reached the address register.
    reg_read(2'd0, SEL_CDA, d);
    check(d, 8'h00);
    // Every block size, checking the old value holds until the cycle ends.
    for (int s = 0; s < 4; s++) begin
      reg_write(2'd0, SEL_SWP, {4'h0, 1'b1, 2'(s), 1'b0}, 1, k, b);
      check({6'h0, prot_a.block_size}, (s == 0) ? 8'h03 : 8'(s - 1));
      wait_idle();
      check({7'h0, prot_a.enable}, 8'h01);
      check({4'h0, prot_a.quarter_mask}, {4'h0, 4'(4'hF << (3 - s))});
    end
    reg_write(2'd0, SEL_SWP, 8'h02, 2, k, b);
    check({7'h0, b}, 8'h00);
    // Write control high refuses data on both registers.
    write_control_n <= 1'b1;
    reg_write(2'd0, SEL_SWP, 8'h00, 1, k, b);
    check({7'h0, k}, 8'h00);
    reg_write(2'd0, SEL_CDA, 8'h00, 1, k, b);
    check({6'h0, k, b}, 8'h00);
    write_control_n <= 1'b0;
    reg_read(2'd0, SEL_SWP, d);
    check(d, 8'h0E);
    // Move the address to 10; the old address must stop answering.
    reg_write(2'd0, SEL_CDA, 8'hFA, 1, k, b);
    check({6'h0, ce_a}, 8'h00);
    wait_idle();
    check({6'h0, ce_a}, 8'h02);
    probe(2'd0, k);
    check({7'h0, k}, 8'h00);
    reg_read(2'd2, SEL_CDA, d);
    check(d, 8'h08);
    reg_write(2'd2, SEL_CDA, 8'h05, 2, k, b);
    check({7'h0, b}, 8'h00);
    // Address and lock together, then the lock holds.
    reg_write(2'd2, SEL_CDA, 8'h05, 1, k, b);
    wait_idle();
    reg_read(2'd1, SEL_CDA, d);
    check(d, 8'h05);
    reg_write(2'd1, SEL_CDA, 8'h00, 1, k, b);
    check({6'h0, k, b}, 8'h00);
    reg_read(2'd1, SEL_CDA, d);
    check(d, 8'h05);
    reg_write(2'd3, SEL_CDA, 8'h00, 1, k, b);
    check({6'h0, k, b}, 8'h00);
    // Protection lock.
    reg_write(2'd1, SEL_SWP, 8'h01, 1, k, b);
    wait_idle();
    reg_write(2'd1, SEL_SWP, 8'h0E, 1, k, b);
    check({6'h0, k, b}, 8'h00);
    reg_read(2'd1, SEL_SWP, d);
    check(d, 8'h01);
    // Power-up again restores the factory contents, not the stored images.
    do_reset();
    check({6'h0, ce_a}, 8'h00);
    reg_read(2'd0, SEL_SWP, d);
    check(d, SWP_RESET);
    tally_and_finish();
  end
endmodule : tb_top
